// ### hdl/gpio_port.v
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module gpio_port #(
    parameter ADDR_W = 8
) (
    // apb clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // port pins
    input  wire [7:0]        pin_in,
    output reg  [7:0]        pin_out,
    output reg  [7:0]        pin_oe,
    // interrupt
    output reg               irq
);

    // ======================================================================
    // state
    // ======================================================================
    reg  [7:0]  out_q;
    reg  [7:0]  dir_q;
    reg  [7:0]  ie_q;
    reg  [7:0]  lock_q;
    reg  [7:0]  sync1_q;
    reg  [7:0]  sync2_q;
    reg  [7:0]  prev_q;
    reg  [15:0] flags_q;
    reg  [15:0] en_q;
    reg  [4:0]  thr_q;

    wire [7:0]  levels;
    wire [15:0] evt_set;
    wire [15:0] pend_en;
    wire [15:0] below_thr;
    reg  [4:0]  vno;
    integer     k;

    // ======================================================================
    // apb decode
    // ======================================================================
    wire        access = psel & penable;
    wire        done   = access & pready;
    wire        wr_go  = done & pwrite;
    wire [5:0]  idx    = paddr[7:2];
    wire        aligned = (paddr[1:0] == 2'b00);

    reg         hit;
    reg  [15:0] rdata;

    always @* begin
        hit   = aligned;
        rdata = 16'h0000;
        if (idx == `IDX_OUTPUT_VALUE) begin
            rdata = {8'h00, out_q};
        end else if (idx == `IDX_PIN_DIRECTION) begin
            rdata = {8'h00, dir_q};
        end else if (idx == `IDX_PIN_LEVELS) begin
            rdata = {8'h00, levels};
        end else if (idx == `IDX_INPUT_PATH_ENABLE) begin
            rdata = {8'h00, ie_q};
        end else if (idx == `IDX_CONFIG_WRITE_LOCK) begin
            rdata = {8'h00, lock_q};
        end else if (idx == `IDX_EDGE_EVENT_FLAGS) begin
            rdata = flags_q;
        end else if (idx == `IDX_SOURCE_ENABLES) begin
            rdata = en_q;
        end else if (idx == `IDX_ENABLE_BY_VECTOR) begin
            rdata = 16'h0000;
        end else if (idx == `IDX_DISABLE_BY_VECTOR) begin
            rdata = 16'h0000;
        end else if (idx == `IDX_NESTING_THRESHOLD) begin
            rdata = {11'h000, thr_q};
        end else if (idx == `IDX_ACTIVE_VECTOR) begin
            rdata = {11'h000, vno};
        end else begin
            hit = 1'b0;
        end
    end

    wire wr_out  = wr_go & hit & (idx == `IDX_OUTPUT_VALUE);
    wire wr_dir  = wr_go & hit & (idx == `IDX_PIN_DIRECTION);
    wire wr_ie   = wr_go & hit & (idx == `IDX_INPUT_PATH_ENABLE);
    wire wr_lock = wr_go & hit & (idx == `IDX_CONFIG_WRITE_LOCK);
    wire wr_flag = wr_go & hit & (idx == `IDX_EDGE_EVENT_FLAGS);
    wire wr_en   = wr_go & hit & (idx == `IDX_SOURCE_ENABLES);
    wire wr_ven  = wr_go & hit & (idx == `IDX_ENABLE_BY_VECTOR);
    wire wr_vdis = wr_go & hit & (idx == `IDX_DISABLE_BY_VECTOR);
    wire wr_thr  = wr_go & hit & (idx == `IDX_NESTING_THRESHOLD);
    wire wr_vno  = wr_go & hit & (idx == `IDX_ACTIVE_VECTOR);

    // one wait state: pready rises on the edge after the access phase begins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (access & ~pready) begin
            pready  <= 1'b1;
            pslverr <= ~hit;
            // refused or write transfers answer with zero data
            prdata  <= (pwrite | ~hit) ? 32'h0000_0000 : {16'h0000, rdata};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // ======================================================================
    // pin configuration
    // ======================================================================
    wire [7:0] wr8 = pwdata[`PORT_MSB:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q  <= `RST_PORT;
            dir_q  <= `RST_PORT;
            ie_q   <= `RST_PORT;
            lock_q <= `RST_PORT;
        end else begin
            if (wr_out) begin
                out_q <= wr8;
            end
            if (wr_dir) begin
                dir_q <= (dir_q & lock_q) | (wr8 & ~lock_q);
            end
            if (wr_ie) begin
                ie_q <= (ie_q & lock_q) | (wr8 & ~lock_q);
            end
            if (wr_lock) begin
                lock_q <= lock_q | wr8;
            end
        end
    end

    // pins follow the registers one-to-one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= `RST_PORT;
            pin_oe  <= `RST_PORT;
        end else begin
            pin_out <= (wr_out ? wr8 : out_q);
            pin_oe  <= (wr_dir ? ((dir_q & lock_q) | (wr8 & ~lock_q)) : dir_q);
        end
    end

    // ======================================================================
    // input path and edge events
    // ======================================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q  <= 8'h00;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign levels = sync2_q & ie_q;

    genvar g;
    generate
        for (g = 0; g <= `PORT_MSB; g = g + 1) begin : g_edge
            // prev tracks the pin even while blocked, so enabling never fakes an edge
            assign evt_set[2*g]   = ie_q[g] & sync2_q[g] & ~prev_q[g];
            assign evt_set[2*g+1] = ie_q[g] & ~sync2_q[g] & prev_q[g];
        end
        for (g = 0; g <= `EVT_MSB; g = g + 1) begin : g_thr
            assign below_thr[g] = (g < thr_q);
        end
    endgenerate

    // ======================================================================
    // interrupt flags, enables, vector logic
    // ======================================================================
    assign pend_en = flags_q & en_q;

    always @* begin
        vno = `NO_VECTOR;
        for (k = `EVT_MSB; k >= 0; k = k - 1) begin
            if (pend_en[k]) begin
                vno = k[4:0];
            end
        end
    end

    reg  [15:0] flag_clr;
    reg  [15:0] en_set;
    reg  [15:0] en_clr;

    always @* begin
        flag_clr = 16'h0000;
        en_set   = 16'h0000;
        en_clr   = 16'h0000;
        if (wr_flag) begin
            flag_clr = pwdata[`EVT_MSB:0];
        end
        if (wr_vno & ~pwdata[`VNO_MSB]) begin
            flag_clr[pwdata[`VNO_EN_MSB:0]] = 1'b1;
        end
        if (wr_ven) begin
            en_set[pwdata[`VNO_EN_MSB:0]] = 1'b1;
        end
        if (wr_vdis) begin
            en_clr[pwdata[`VNO_EN_MSB:0]] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `RST_EVT;
            en_q    <= `RST_EVT;
            thr_q   <= `RST_THRESHOLD;
            irq     <= 1'b0;
        end else begin
            // a new edge wins over a clear in the same cycle
            flags_q <= (flags_q & ~flag_clr) | evt_set;
            if (wr_en) begin
                en_q <= pwdata[`EVT_MSB:0];
            end else begin
                en_q <= (en_q | en_set) & ~en_clr;
            end
            if (wr_thr) begin
                thr_q <= pwdata[`VNO_MSB:0];
            end
            irq <= |(pend_en & below_thr);
        end
    end

endmodule // gpio_port

// ### hdl/gpio_port_map.vh
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// ==========================================================================
// register indices (byte address = index * 4)
// ==========================================================================
`define IDX_OUTPUT_VALUE       6'h00
`define IDX_PIN_DIRECTION      6'h02
`define IDX_PIN_LEVELS         6'h04
`define IDX_INPUT_PATH_ENABLE  6'h06
`define IDX_CONFIG_WRITE_LOCK  6'h08
`define IDX_EDGE_EVENT_FLAGS   6'h30
`define IDX_SOURCE_ENABLES     6'h34
`define IDX_ENABLE_BY_VECTOR   6'h38
`define IDX_DISABLE_BY_VECTOR  6'h3A
`define IDX_NESTING_THRESHOLD  6'h3C
`define IDX_ACTIVE_VECTOR      6'h3E

// ==========================================================================
// field positions
// ==========================================================================
`define PORT_MSB               7
`define EVT_MSB                15
`define VNO_EN_MSB             3
`define VNO_MSB                4

// ==========================================================================
// reset values
// ==========================================================================
`define RST_PORT               8'h00
`define RST_EVT                16'h0000
`define RST_THRESHOLD          5'h08
`define NO_VECTOR              5'h10

`endif

// ### sim/gpio_port_props.sv
`timescale 1ns/1ps
module gpio_port_props #(
    parameter ADDR_W = 8
) (
    // apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // pins and interrupt
    input wire logic [7:0]        pin_in,
    input wire logic [7:0]        pin_out,
    input wire logic [7:0]        pin_oe,
    input wire logic              irq
);
    // ==========================================================================
    // apb and port checks
    // ==========================================================================
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence access_wait;
        psel && penable && !pready;
    endsequence
    sequence write_done(a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence

    chk_ready_wait: assert property (access_wait |=> pready)
        else $error("pready missing one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_err_unaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access without pslverr");
    chk_rdata_quiet: assert property (!pready || pslverr |-> prdata == 32'h00000000)
        else $error("prdata not zero outside a good answer");
    chk_out_write: assert property (write_done(8'h00) |=> pin_out == $past(pwdata[7:0]))
        else $error("pin_out does not follow written value");
    chk_out_hold: assert property (!$stable(pin_out) |-> $past(pready && pwrite && paddr == 8'h00))
        else $error("pin_out changed without a write");
    chk_oe_hold: assert property (!$stable(pin_oe) |-> $past(pready && pwrite && paddr == 8'h08))
        else $error("pin_oe changed without a direction write");
    chk_irq_none: assert property (pready && !pwrite && paddr == 8'hF8 && prdata[4:0] == 5'h10 |-> !irq)
        else $error("irq high while no source is pending");
endmodule // gpio_port_props

// ### sim/pin_partner.sv
`timescale 1ns/1ps
// pin level: own driver where enabled, else the outside world
module pin_partner (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_level,
    output wire logic [7:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_partner

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    // ==========================================================================
    // signals and instances
    // ==========================================================================
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, ext_level = 8'h00;
    logic [31:0] pwdata = 32'h00000000, rdat;
    logic        rerr;
    wire  [31:0] prdata;
    wire  [7:0]  pin_in, pin_out, pin_oe;
    wire         pready, pslverr, irq;
    int          err_total = 0, n_compared = 0, cycles = 0;
    logic [7:0]  ra [9] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'hC0, 8'hD0, 8'hF0, 8'hF8};

    always #5 pclk = ~pclk;

    gpio_port #(.ADDR_W(8)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq(irq)
    );
    pin_partner pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

    // ==========================================================================
    // tasks
    // ==========================================================================
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        chk(rdat, e);
    endtask

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            finish_test();
        end
    end

    // ==========================================================================
    // tests
    // ==========================================================================
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rc(ra[i], i == 7 ? 32'h00000008 : i == 8 ? 32'h00000010 : 32'h00000000);
        rc(8'h40, 32'h00000000);
        chk({31'h0, rerr}, 32'h00000001);
        wr(8'h00, 32'h000000A5);
        wr(8'h08, 32'h0000000F);
        #1;
        chk({16'h0000, pin_oe, pin_out}, 32'h00000FA5);
        rc(8'h10, 32'h00000000);
        wr(8'h18, 32'h000000FF);
        rc(8'h10, 32'h00000005);
        wr(8'h20, 32'h00000001);
        wr(8'h20, 32'h00000000);
        rc(8'h20, 32'h00000001);
        wr(8'h08, 32'h00000000);
        wr(8'h18, 32'h00000020);
        rc(8'h08, 32'h00000001);
        rc(8'h18, 32'h00000021);
        wr(8'hC0, 32'h0000FFFF);
        rc(8'hC0, 32'h00000000);
        ext_level[5] <= 1'b1;
        repeat (5) @(posedge pclk);
        rc(8'hC0, 32'h00000400);
        ext_level[5] <= 1'b0;
        repeat (5) @(posedge pclk);
        rc(8'hC0, 32'h00000C00);
        wr(8'hE0, 32'h0000000A);
        wr(8'hE0, 32'h0000000B);
        rc(8'hD0, 32'h00000C00);
        wr(8'hE8, 32'h0000000A);
        rc(8'hD0, 32'h00000800);
        rc(8'hF8, 32'h0000000B);
        chk({31'h0, irq}, 32'h00000000);
        wr(8'hF0, 32'h00000010);
        rc(8'hF0, 32'h00000010);
        chk({31'h0, irq}, 32'h00000001);
        wr(8'hF8, 32'h0000000B);
        rc(8'hC0, 32'h00000400);
        rc(8'hF8, 32'h00000010);
        chk({31'h0, irq}, 32'h00000000);
        wr(8'hD0, 32'h0000FFFF);
        rc(8'hF8, 32'h0000000A);
        chk({31'h0, irq}, 32'h00000001);
        wr(8'hF0, 32'h0000000A);
        rc(8'hF0, 32'h0000000A);
        chk({31'h0, irq}, 32'h00000000);
        finish_test();
    end
endmodule // testbench

bind gpio_port gpio_port_props #(.ADDR_W(ADDR_W)) props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq)
);
